// ### rtl/hp_pkg.sv
// shared constants for the dual channel host port decode block
package hp_pkg;
  localparam int HP_DW = 8;
  localparam int HP_AW = 16;
  localparam int HP_NCH = 2;
  localparam int HP_SYNC_W = 24;
  // on-chip cpu register addresses
  localparam logic [15:0] HP_ADDR_SERIAL_TIMER_CONTROL = 16'hFFC3;
  localparam logic [15:0] HP_ADDR_SYSTEM_CONTROL = 16'hFFC4;
  localparam logic [15:0] HP_ADDR_HOST_PORT_CONTROL = 16'hFFF0;
  localparam logic [15:0] HP_ADDR_IN1 = 16'hFFF4;
  localparam logic [15:0] HP_ADDR_OUT1 = 16'hFFF5;
  localparam logic [15:0] HP_ADDR_ST1 = 16'hFFF6;
  localparam logic [15:0] HP_ADDR_IN2 = 16'hFFFC;
  localparam logic [15:0] HP_ADDR_OUT2 = 16'hFFFD;
  localparam logic [15:0] HP_ADDR_ST2 = 16'hFFFE;
  // reset values
  localparam logic [7:0] HP_RST_SERIAL_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] HP_RST_SYSTEM_CONTROL = 8'h09;
  localparam logic [7:0] HP_RST_HOST_PORT_CONTROL = 8'hF8;
  localparam logic [7:0] HP_RST_STATE = 8'h00;
  localparam logic [7:0] HP_RST_BYTE = 8'h00;
  // field positions and masks
  localparam int HP_SYSTEM_CONTROL_ENABLE_BIT = 1;
  localparam int HP_SYSTEM_CONTROL_RO_BIT = 3;
  localparam logic [7:0] HP_SYSTEM_CONTROL_RO_MASK = 8'h08;
  localparam logic [7:0] HP_HOST_PORT_CONTROL_WR_MASK = 8'h07;
  localparam logic [7:0] HP_HOST_PORT_CONTROL_ONES = 8'hF8;
  localparam int HP_HOST_PORT_CONTROL_IE1_BIT = 1;
  localparam int HP_HOST_PORT_CONTROL_IE2_BIT = 2;
  localparam int HP_SERIAL_TIMER_CONTROL_SWAP_BIT = 0;
  localparam logic [7:0] HP_STATE_USER_MASK = 8'hF0;
  localparam int HP_STATE_CD_BIT = 3;
  localparam int HP_STATE_IBF_BIT = 1;
  localparam int HP_STATE_OBF_BIT = 0;
  // positions inside the synchronised pin vector
  localparam int HP_P_RD = 0;
  localparam int HP_P_WR = 1;
  localparam int HP_P_ALT_WR = 2;
  localparam int HP_P_CSA = 3;
  localparam int HP_P_CSB = 4;
  localparam int HP_P_ALT_CSB = 5;
  localparam int HP_P_HA = 6;
  localparam int HP_P_EXP = 7;
  localparam int HP_P_DS = 8;
  localparam int HP_P_DX = 16;
  // strobes and selects idle high
  localparam logic [23:0] HP_SYNC_RST = 24'h00003F;
endpackage : hp_pkg

// ### rtl/hp_pin_sync.sv
// three flop pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module hp_pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } hp_sync_s;

  hp_sync_s st_ff;
  hp_sync_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pin_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // a bit only moves when stages two and three agree, so glitches are held off
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.lvl[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.lvl;
endmodule : hp_pin_sync
`default_nettype wire

// ### rtl/hp_chan.sv
// one host port channel: input byte, output byte and state byte
`timescale 1ns/10ps
`default_nettype none
module hp_chan
  import hp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic host_wr_stb,
  input wire logic [hp_pkg::HP_DW-1:0] host_wr_data,
  input wire logic host_wr_cmd,
  input wire logic host_rd_done,
  input wire logic cpu_in_rd,
  input wire logic cpu_out_wr,
  input wire logic cpu_state_wr,
  input wire logic [hp_pkg::HP_DW-1:0] cpu_wdata,
  output logic [hp_pkg::HP_DW-1:0] in_byte,
  output logic [hp_pkg::HP_DW-1:0] out_byte,
  output logic [hp_pkg::HP_DW-1:0] state
);
  typedef struct packed {
    logic [7:0] in_b;
    logic [7:0] out_b;
    logic [7:0] st;
  } hp_chan_s;

  hp_chan_s c_ff;
  hp_chan_s nxt_c;

  always_comb begin
    nxt_c = c_ff;
    if (cpu_state_wr) begin
      nxt_c.st = (c_ff.st & ~HP_STATE_USER_MASK) | (cpu_wdata & HP_STATE_USER_MASK); // [RULE11]
    end
    // clears first, sets after, so a set in the same cycle wins
    if (cpu_in_rd) begin
      nxt_c.st[HP_STATE_IBF_BIT] = 1'b0; // [RULE16]
    end
    if (host_rd_done) begin
      nxt_c.st[HP_STATE_OBF_BIT] = 1'b0; // [RULE17]
    end
    if (host_wr_stb) begin
      nxt_c.in_b = host_wr_data; // [RULE15]
      nxt_c.st[HP_STATE_CD_BIT] = host_wr_cmd; // [RULE6]
      nxt_c.st[HP_STATE_IBF_BIT] = 1'b1; // [RULE16]
    end
    if (cpu_out_wr) begin
      nxt_c.out_b = cpu_wdata; // [RULE10]
      nxt_c.st[HP_STATE_OBF_BIT] = 1'b1; // [RULE17]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c_ff <= '{in_b: HP_RST_BYTE, out_b: HP_RST_BYTE, st: HP_RST_STATE}; // [RULE11]
    end else begin
      c_ff <= nxt_c;
    end
  end

  assign in_byte = c_ff.in_b;
  assign out_byte = c_ff.out_b;
  assign state = c_ff.st;
endmodule : hp_chan
`default_nettype wire

// ### rtl/hp_port.sv
// dual channel host port: pin decode, host access and on-chip register file
// How it works
// RULE1: a low read strobe from the host is taken as a host read request.
// RULE2: a low write strobe from the host is taken as a host write request.
// RULE3: channel 1 is addressed when select a is low and select b is high.
// RULE4: channel 2 is addressed when select b is low and select a is high.
// RULE5: host read returns output byte when address select is 0, state when 1.
// RULE6: host write always fills input byte; address select marks command or data.
// RULE7: single-chip mode uses one host bus pin group, expanded modes the other.
// RULE8: pin swap bit 0 uses primary write strobe and select b, 1 the alternates.
// RULE9: input bytes are host write-only, cpu read-only at FFF4 and FFFC.
// RULE10: output bytes are cpu read/write, host read-only, at FFF5 and FFFD.
// RULE11: cpu writes only state bits 7..4; host reads only; state resets to zero.
// RULE12: system control bit 3 is read-only to the cpu; register resets to 09.
// RULE13: three host interrupt request outputs drive lines toward the host.
// RULE14: the host port responds only while the port enable bit is 1.
// RULE15: at the write strobe rising edge the byte and command level are latched.
// RULE16: input full sets on host write, clears on cpu read, and interrupts the cpu.
// RULE17: output full sets on cpu write of output byte, clears on host read.
// RULE18: host pins are synchronised so every host access acts exactly once.
`timescale 1ns/10ps
`default_nettype none
module hp_port
  import hp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  // on-chip cpu register access
  input wire logic cpu_sel,
  input wire logic cpu_we,
  input wire logic [hp_pkg::HP_AW-1:0] cpu_addr,
  input wire logic [hp_pkg::HP_DW-1:0] cpu_wdata,
  output logic [hp_pkg::HP_DW-1:0] cpu_rdata,
  output logic cpu_ack,
  output logic [hp_pkg::HP_NCH-1:0] cpu_in_full_irq,
  // host pins
  input wire logic host_rd_strobe_n,
  input wire logic host_wr_strobe_n,
  input wire logic alt_host_wr_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic alt_chan_b_select_n,
  input wire logic host_cmd_or_status_sel,
  input wire logic expanded_mode,
  input wire logic [hp_pkg::HP_DW-1:0] host_bus_pins_single_chip_i,
  output logic [hp_pkg::HP_DW-1:0] host_bus_pins_single_chip_o,
  output logic host_bus_pins_single_chip_oe,
  input wire logic [hp_pkg::HP_DW-1:0] host_bus_pins_expanded_i,
  output logic [hp_pkg::HP_DW-1:0] host_bus_pins_expanded_o,
  output logic host_bus_pins_expanded_oe,
  output logic host_irq_line_a,
  output logic host_irq_line_b,
  output logic host_irq_line_c,
  output logic addr_gate_out
);
  typedef struct packed {
    logic [7:0] serial_timer_control;
    logic [7:0] system_control;
    logic [7:0] host_port_control;
    logic [7:0] cpu_rdata;
    logic cpu_ack;
    logic [7:0] host_dout;
    logic oe_single;
    logic oe_exp;
    logic wr_act;
    logic [1:0] wr_ch;
    logic [7:0] wr_data;
    logic wr_cmd;
    logic rd_act;
    logic [1:0] rd_ch;
    logic rd_stat;
    logic [2:0] irq;
  } hp_port_s;

  hp_port_s r_ff;
  hp_port_s nxt_r;

  logic [HP_SYNC_W-1:0] pin_raw;
  logic [HP_SYNC_W-1:0] pin_lvl;

  // every host pin goes through the filtered synchroniser before use
  assign pin_raw = {host_bus_pins_expanded_i, host_bus_pins_single_chip_i, expanded_mode,
                    host_cmd_or_status_sel, alt_chan_b_select_n, chan_b_select_n,
                    chan_a_select_n, alt_host_wr_strobe_n, host_wr_strobe_n,
                    host_rd_strobe_n};

  hp_pin_sync #(
    .W(HP_SYNC_W),
    .RST_VAL(HP_SYNC_RST)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(pin_raw),
    .level_out(pin_lvl)
  ); // [RULE18]

  // decoded host side
  logic port_en;
  logic swap;
  logic rd_n;
  logic wr_n;
  logic csa_n;
  logic csb_n;
  logic ha;
  logic exp_mode;
  logic [7:0] host_din;
  logic [1:0] ch_hit;

  always_comb begin
    port_en = r_ff.system_control[HP_SYSTEM_CONTROL_ENABLE_BIT]; // [RULE14]
    swap = r_ff.serial_timer_control[HP_SERIAL_TIMER_CONTROL_SWAP_BIT];
    rd_n = pin_lvl[HP_P_RD]; // [RULE1]
    wr_n = swap ? pin_lvl[HP_P_ALT_WR] : pin_lvl[HP_P_WR]; // [RULE2] [RULE8]
    csa_n = pin_lvl[HP_P_CSA];
    csb_n = swap ? pin_lvl[HP_P_ALT_CSB] : pin_lvl[HP_P_CSB]; // [RULE8]
    ha = pin_lvl[HP_P_HA];
    exp_mode = pin_lvl[HP_P_EXP];
    host_din = exp_mode ? pin_lvl[HP_P_DX +: 8] : pin_lvl[HP_P_DS +: 8]; // [RULE7]
    // both selects low addresses nothing rather than two channels at once
    ch_hit[0] = !csa_n && csb_n; // [RULE3]
    ch_hit[1] = !csb_n && csa_n; // [RULE4]
  end

  // per channel strobes and views
  logic [HP_NCH-1:0] host_wr_stb;
  logic [HP_NCH-1:0] host_rd_done;
  logic [HP_NCH-1:0] cpu_in_rd;
  logic [HP_NCH-1:0] cpu_out_wr;
  logic [HP_NCH-1:0] cpu_state_wr;
  logic [7:0] ch_in [HP_NCH];
  logic [7:0] ch_out [HP_NCH];
  logic [7:0] ch_state [HP_NCH];

  logic cpu_rd;
  logic cpu_wr;
  assign cpu_rd = cpu_sel && !cpu_we;
  assign cpu_wr = cpu_sel && cpu_we;

  genvar gi;
  generate
    for (gi = 0; gi < HP_NCH; gi++) begin : g_ch
      localparam logic [15:0] A_IN = (gi == 0) ? HP_ADDR_IN1 : HP_ADDR_IN2;
      localparam logic [15:0] A_OUT = (gi == 0) ? HP_ADDR_OUT1 : HP_ADDR_OUT2;
      localparam logic [15:0] A_ST = (gi == 0) ? HP_ADDR_ST1 : HP_ADDR_ST2;
      // the write is acted on once, at the synchronised rising edge
      assign host_wr_stb[gi] = r_ff.wr_act && wr_n && r_ff.wr_ch[gi]; // [RULE15] [RULE18]
      // only the end of an output byte read empties it; a state read leaves it
      assign host_rd_done[gi] = r_ff.rd_act && rd_n && r_ff.rd_ch[gi] && !r_ff.rd_stat; // [RULE17]
      assign cpu_in_rd[gi] = cpu_rd && (cpu_addr == A_IN); // [RULE9] [RULE16]
      assign cpu_out_wr[gi] = cpu_wr && (cpu_addr == A_OUT); // [RULE10]
      assign cpu_state_wr[gi] = cpu_wr && (cpu_addr == A_ST); // [RULE11]

      hp_chan u_chan (
        .clk(clk),
        .sys_rst(sys_rst),
        .host_wr_stb(host_wr_stb[gi]),
        .host_wr_data(r_ff.wr_data),
        .host_wr_cmd(r_ff.wr_cmd),
        .host_rd_done(host_rd_done[gi]),
        .cpu_in_rd(cpu_in_rd[gi]),
        .cpu_out_wr(cpu_out_wr[gi]),
        .cpu_state_wr(cpu_state_wr[gi]),
        .cpu_wdata(cpu_wdata),
        .in_byte(ch_in[gi]),
        .out_byte(ch_out[gi]),
        .state(ch_state[gi])
      );
    end
  endgenerate

  logic [7:0] rd_mux;
  logic [1:0] cur_ch;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.cpu_ack = cpu_sel;
    rd_mux = 8'h00;
    cur_ch = 2'b00;

    // cpu register writes; writes to input bytes are ignored
    if (cpu_wr) begin
      case (cpu_addr)
        HP_ADDR_SERIAL_TIMER_CONTROL: nxt_r.serial_timer_control = cpu_wdata;
        HP_ADDR_SYSTEM_CONTROL: begin
          nxt_r.system_control = (cpu_wdata & ~HP_SYSTEM_CONTROL_RO_MASK) | (r_ff.system_control & HP_SYSTEM_CONTROL_RO_MASK); // [RULE12]
        end
        HP_ADDR_HOST_PORT_CONTROL: nxt_r.host_port_control = (cpu_wdata & HP_HOST_PORT_CONTROL_WR_MASK) | HP_HOST_PORT_CONTROL_ONES;
        default: nxt_r.serial_timer_control = r_ff.serial_timer_control;
      endcase
    end

    // cpu register reads; unmapped addresses read zero
    if (cpu_rd) begin
      case (cpu_addr)
        HP_ADDR_SERIAL_TIMER_CONTROL: nxt_r.cpu_rdata = r_ff.serial_timer_control;
        HP_ADDR_SYSTEM_CONTROL: nxt_r.cpu_rdata = r_ff.system_control;
        HP_ADDR_HOST_PORT_CONTROL: nxt_r.cpu_rdata = r_ff.host_port_control;
        HP_ADDR_IN1: nxt_r.cpu_rdata = ch_in[0]; // [RULE9]
        HP_ADDR_OUT1: nxt_r.cpu_rdata = ch_out[0]; // [RULE10]
        HP_ADDR_ST1: nxt_r.cpu_rdata = ch_state[0];
        HP_ADDR_IN2: nxt_r.cpu_rdata = ch_in[1]; // [RULE9]
        HP_ADDR_OUT2: nxt_r.cpu_rdata = ch_out[1]; // [RULE10]
        HP_ADDR_ST2: nxt_r.cpu_rdata = ch_state[1];
        default: nxt_r.cpu_rdata = 8'h00;
      endcase
    end

    // host write: hold the bus byte while the strobe is low, commit at the rise
    if (r_ff.wr_act) begin
      if (wr_n) begin
        nxt_r.wr_act = 1'b0;
      end else begin
        nxt_r.wr_data = host_din;
        nxt_r.wr_cmd = ha; // [RULE6]
      end
    end else if (port_en && !wr_n && (ch_hit != 2'b00)) begin // [RULE14] [RULE2]
      nxt_r.wr_act = 1'b1;
      nxt_r.wr_ch = ch_hit;
      nxt_r.wr_data = host_din;
      nxt_r.wr_cmd = ha; // [RULE6]
    end

    // host read: channel and address select frozen for the whole strobe
    if (r_ff.rd_act) begin
      if (rd_n) begin
        nxt_r.rd_act = 1'b0;
      end
    end else if (port_en && !rd_n && (ch_hit != 2'b00)) begin // [RULE14] [RULE1]
      nxt_r.rd_act = 1'b1;
      nxt_r.rd_ch = ch_hit;
      nxt_r.rd_stat = ha;
    end
    cur_ch = r_ff.rd_act ? r_ff.rd_ch : ch_hit;
    if (cur_ch[1]) begin
      rd_mux = r_ff.rd_stat ? ch_state[1] : ch_out[1]; // [RULE5]
    end else begin
      rd_mux = r_ff.rd_stat ? ch_state[0] : ch_out[0]; // [RULE5]
    end
    nxt_r.host_dout = rd_mux;
    // drive only during an accepted read, and only on the group of the current mode
    nxt_r.oe_single = nxt_r.rd_act && !rd_n && !exp_mode; // [RULE7]
    nxt_r.oe_exp = nxt_r.rd_act && !rd_n && exp_mode; // [RULE7]
    if (!r_ff.rd_act) begin
      nxt_r.host_dout = ha ? (ch_hit[1] ? ch_state[1] : ch_state[0])
                           : (ch_hit[1] ? ch_out[1] : ch_out[0]); // [RULE5]
    end

    // host interrupt lines follow output full while the port is on
    nxt_r.irq[0] = port_en && ch_state[0][HP_STATE_OBF_BIT]; // [RULE13]
    nxt_r.irq[1] = port_en && ch_state[1][HP_STATE_OBF_BIT]; // [RULE13]
    nxt_r.irq[2] = port_en && (ch_state[0][HP_STATE_OBF_BIT] || ch_state[1][HP_STATE_OBF_BIT]); // [RULE13]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_ff <= '{serial_timer_control: HP_RST_SERIAL_TIMER_CONTROL, system_control: HP_RST_SYSTEM_CONTROL, host_port_control: HP_RST_HOST_PORT_CONTROL, // [RULE12]
                cpu_rdata: 8'h00, cpu_ack: 1'b0, host_dout: 8'h00, oe_single: 1'b0,
                oe_exp: 1'b0, wr_act: 1'b0, wr_ch: 2'b00, wr_data: 8'h00, wr_cmd: 1'b0,
                rd_act: 1'b0, rd_ch: 2'b00, rd_stat: 1'b0, irq: 3'b000};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign cpu_rdata = r_ff.cpu_rdata;
  assign cpu_ack = r_ff.cpu_ack;
  assign cpu_in_full_irq[0] = ch_state[0][HP_STATE_IBF_BIT] && r_ff.host_port_control[HP_HOST_PORT_CONTROL_IE1_BIT]; // [RULE16]
  assign cpu_in_full_irq[1] = ch_state[1][HP_STATE_IBF_BIT] && r_ff.host_port_control[HP_HOST_PORT_CONTROL_IE2_BIT]; // [RULE16]
  assign host_bus_pins_single_chip_o = r_ff.host_dout;
  assign host_bus_pins_single_chip_oe = r_ff.oe_single;
  assign host_bus_pins_expanded_o = r_ff.host_dout;
  assign host_bus_pins_expanded_oe = r_ff.oe_exp;
  assign host_irq_line_a = r_ff.irq[0];
  assign host_irq_line_b = r_ff.irq[1];
  assign host_irq_line_c = r_ff.irq[2];
  // fast gate logic is not built here; the gate line rests high
  assign addr_gate_out = 1'b1;
endmodule : hp_port
`default_nettype wire

// ### verif/hp_port_asserts.sv
// assertion checker for the host port cpu bus and host pins
`timescale 1ns/10ps
`default_nettype none
module hp_port_asserts
  import hp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cpu_sel,
  input wire logic cpu_we,
  input wire logic [hp_pkg::HP_AW-1:0] cpu_addr,
  input wire logic [hp_pkg::HP_DW-1:0] cpu_wdata,
  input wire logic [hp_pkg::HP_DW-1:0] cpu_rdata,
  input wire logic cpu_ack,
  input wire logic [hp_pkg::HP_NCH-1:0] cpu_in_full_irq,
  input wire logic host_rd_strobe_n,
  input wire logic host_bus_pins_single_chip_oe,
  input wire logic host_bus_pins_expanded_oe,
  input wire logic host_irq_line_a,
  input wire logic host_irq_line_b,
  input wire logic host_irq_line_c
);
  logic en_ff;
  logic [1:0] ie_ff;
  wire logic rd_c = cpu_sel && !cpu_we;
  wire logic wr_c = cpu_sel && cpu_we;
  wire logic oe_any = host_bus_pins_single_chip_oe || host_bus_pins_expanded_oe;
  // shadow of the enable bits, so pin behaviour can be tied to them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_ff <= 1'b0;
      ie_ff <= 2'h0;
    end else if (wr_c && cpu_addr == HP_ADDR_SYSTEM_CONTROL) begin
      en_ff <= cpu_wdata[HP_SYSTEM_CONTROL_ENABLE_BIT];
    end else if (wr_c && cpu_addr == HP_ADDR_HOST_PORT_CONTROL) begin
      ie_ff <= cpu_wdata[2:1];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_ack; cpu_sel |=> cpu_ack; endproperty
  a_ack: assert property (p_ack)
    else $error("cpu access not acknowledged");
  property p_sysro; rd_c && cpu_addr == HP_ADDR_SYSTEM_CONTROL |=> cpu_rdata[3]; endproperty
  a_sysro: assert property (p_sysro)
    else $error("read-only control bit lost");
  property p_st2; rd_c && cpu_addr[2:0] == 3'h6 |=> !cpu_rdata[2]; endproperty
  a_st2: assert property (p_st2)
    else $error("unwritable state bit set");
  property p_excl; !(host_bus_pins_single_chip_oe && host_bus_pins_expanded_oe); endproperty
  a_excl: assert property (p_excl)
    else $error("both data groups driven");
  property p_oe_rise; $rose(oe_any) |-> $past(host_rd_strobe_n, 3) == 1'b0; endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("data driven without read strobe");
  property p_oe_fall; host_rd_strobe_n [*8] |-> !oe_any; endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("data still driven after read");
  property p_irqc; host_irq_line_c == (host_irq_line_a || host_irq_line_b); endproperty
  a_irqc: assert property (p_irqc)
    else $error("combined host irq wrong");
  property p_dis; !en_ff [*2] |-> !host_irq_line_c && !oe_any; endproperty
  a_dis: assert property (p_dis)
    else $error("disabled port active");
  property p_cirq; (cpu_in_full_irq & ~ie_ff) == 2'h0; endproperty
  a_cirq: assert property (p_cirq)
    else $error("masked input irq raised");
endmodule : hp_port_asserts
bind hp_port hp_port_asserts i_hp_port_asserts (.clk, .sys_rst, .cpu_sel, .cpu_we,
  .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_ack, .cpu_in_full_irq, .host_rd_strobe_n,
  .host_bus_pins_single_chip_oe, .host_bus_pins_expanded_oe, .host_irq_line_a,
  .host_irq_line_b, .host_irq_line_c);
`default_nettype wire

// ### verif/hp_host_model.sv
// behavioural host processor on the parallel port pins
`timescale 1ns/10ps
`default_nettype none
module hp_host_model (
  input wire logic clk,
  input wire logic [7:0] bus,
  output logic rd_n,
  output logic wr_n,
  output logic awr_n,
  output logic csa_n,
  output logic csb_n,
  output logic acsb_n,
  output logic ha,
  output logic [7:0] d
);
  initial begin
    {rd_n, wr_n, awr_n, csa_n, csb_n, acsb_n} = 6'h3F;
    ha = 1'b0;
    d = 8'h5A;
  end
  // ch 1 or 2 picks a channel; 3 drops both selects, an illegal access
  task automatic acc(input bit w, input int ch, input bit sel, input bit swp,
      input logic [7:0] wd, output logic [7:0] rd);
    @(negedge clk);
    csa_n = !ch[0];
    if (swp) acsb_n = !ch[1];
    else csb_n = !ch[1];
    ha = sel;
    if (w) d = wd;
    repeat (2) @(negedge clk);
    if (!w) rd_n = 1'b0;
    else if (swp) awr_n = 1'b0;
    else wr_n = 1'b0;
    // long strobe: the pin filter drops anything seen for only one 4 ns cycle
    repeat (10) @(negedge clk);
    rd = bus;
    {rd_n, wr_n, awr_n} = 3'h7;
    repeat (2) @(negedge clk);
    {csa_n, csb_n, acsb_n} = 3'h7;
    d = ~d;
    repeat (8) @(negedge clk);
  endtask : acc
endmodule : hp_host_model
`default_nettype wire

// ### verif/dual_channel_host_port_decode_tb_top.sv
// self-checking bench for the dual channel host port
`timescale 1ns/10ps
`default_nettype none
module dual_channel_host_port_decode_tb_top;
  import hp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cpu_sel = 1'b0;
  logic cpu_we = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  logic expanded_mode = 1'b0;
  logic [7:0] cpu_rdata, sc_o, ex_o, hd, hbus, sc_i, ex_i;
  logic cpu_ack, sc_oe, ex_oe, irq_a, irq_b, irq_c, gate;
  logic [1:0] cirq;
  logic rd_n, wr_n, awr_n, csa_n, csb_n, acsb_n, ha;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h3927;
  int m_in[2] = '{0, 0};
  int m_out[2] = '{0, 0};
  int m_st[2] = '{0, 0};
  int m_sys = HP_RST_SYSTEM_CONTROL;
  int m_host_port_control = HP_RST_HOST_PORT_CONTROL;
  int m_serial_timer_control = 0;
  localparam logic [15:0] RA[10] = '{HP_ADDR_SERIAL_TIMER_CONTROL, HP_ADDR_SYSTEM_CONTROL, HP_ADDR_HOST_PORT_CONTROL,
    HP_ADDR_IN1, HP_ADDR_OUT1, HP_ADDR_ST1, HP_ADDR_IN2, HP_ADDR_OUT2, HP_ADDR_ST2, 16'hFFF1};
  always #2 clk = ~clk;
  // wire level: the device wins only while it enables its group
  // the group of the other mode shows the inverse, so taking the wrong group is caught
  assign sc_i = sc_oe ? sc_o : (expanded_mode ? ~hd : hd);
  assign ex_i = ex_oe ? ex_o : (expanded_mode ? hd : ~hd);
  assign hbus = expanded_mode ? ex_i : sc_i;
  hp_port i_hp_port (.clk, .sys_rst, .cpu_sel, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_rdata,
    .cpu_ack, .cpu_in_full_irq(cirq), .host_rd_strobe_n(rd_n), .host_wr_strobe_n(wr_n),
    .alt_host_wr_strobe_n(awr_n), .chan_a_select_n(csa_n), .chan_b_select_n(csb_n),
    .alt_chan_b_select_n(acsb_n), .host_cmd_or_status_sel(ha), .expanded_mode,
    .host_bus_pins_single_chip_i(sc_i), .host_bus_pins_single_chip_o(sc_o),
    .host_bus_pins_single_chip_oe(sc_oe), .host_bus_pins_expanded_i(ex_i),
    .host_bus_pins_expanded_o(ex_o), .host_bus_pins_expanded_oe(ex_oe),
    .host_irq_line_a(irq_a), .host_irq_line_b(irq_b), .host_irq_line_c(irq_c),
    .addr_gate_out(gate));
  hp_host_model i_hp_host_model (.clk, .bus(hbus), .rd_n, .wr_n, .awr_n, .csa_n,
    .csb_n, .acsb_n, .ha, .d(hd));
  task automatic end_sim();
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction : rnd
  task automatic cpu(input bit we, input logic [15:0] a, input logic [7:0] wd,
      output logic [7:0] rd);
    @(negedge clk);
    cpu_sel = 1'b1;
    cpu_we = we;
    cpu_addr = a;
    cpu_wdata = wd;
    @(negedge clk);
    cpu_sel = 1'b0;
    rd = cpu_rdata;
  endtask : cpu
  task automatic wr(input logic [15:0] a, input int v);
    logic [7:0] r;
    cpu(1'b1, a, v[7:0], r);
    case (a)
      HP_ADDR_SERIAL_TIMER_CONTROL: m_serial_timer_control = v;
      HP_ADDR_SYSTEM_CONTROL: m_sys = (v & 8'hF7) | 8'h08;
      HP_ADDR_HOST_PORT_CONTROL: m_host_port_control = (v & 8'h07) | 8'hF8;
      HP_ADDR_OUT1, HP_ADDR_OUT2: begin
        m_out[a[3]] = v;
        m_st[a[3]] |= 1;
      end
      HP_ADDR_ST1, HP_ADDR_ST2: m_st[a[3]] = (m_st[a[3]] & 8'h0B) | (v & 8'hF0);
      default: ;
    endcase
  endtask : wr
  task automatic rdc(input logic [15:0] a);
    logic [7:0] r;
    int e;
    case (a)
      HP_ADDR_SERIAL_TIMER_CONTROL: e = m_serial_timer_control;
      HP_ADDR_SYSTEM_CONTROL: e = m_sys;
      HP_ADDR_HOST_PORT_CONTROL: e = m_host_port_control;
      HP_ADDR_IN1, HP_ADDR_IN2: e = m_in[a[3]];
      HP_ADDR_OUT1, HP_ADDR_OUT2: e = m_out[a[3]];
      HP_ADDR_ST1, HP_ADDR_ST2: e = m_st[a[3]];
      default: e = 0;
    endcase
    cpu(1'b0, a, 8'h00, r);
    chk(r, e[7:0]);
    if (a == HP_ADDR_IN1 || a == HP_ADDR_IN2) m_st[a[3]] &= 8'hFD;
  endtask : rdc
  task automatic host(input bit w, input int ch, input bit sel, input bit swp);
    logic [7:0] v, r;
    int c;
    bit ok;
    v = rnd();
    c = ch - 1;
    ok = ch < 3 && m_sys[1] && swp == m_serial_timer_control[0];
    i_hp_host_model.acc(w, ch, sel, swp, v, r);
    if (ok && w) begin
      m_in[c] = v;
      m_st[c] = (m_st[c] & 8'hF5) | (sel << 3) | 2;
    end
    if (ok && !w) begin
      chk(r, sel ? m_st[c][7:0] : m_out[c][7:0]);
      if (!sel) m_st[c] &= 8'hFE;
    end
  endtask : host
  task automatic irqs();
    int a, b;
    a = m_st[0] & 1;
    b = m_st[1] & 1;
    repeat (3) @(negedge clk);
    chk({4'h0, gate, irq_c, irq_b, irq_a}, 8'(8 | (a | b) << 2 | b << 1 | a));
  endtask : irqs
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    foreach (RA[i]) rdc(RA[i]);
    host(1'b1, 1, 1'b0, 1'b0);
    rdc(HP_ADDR_ST1);
    wr(HP_ADDR_SYSTEM_CONTROL, 8'hF7);
    rdc(HP_ADDR_SYSTEM_CONTROL);
    wr(HP_ADDR_SYSTEM_CONTROL, 8'h02);
    wr(HP_ADDR_HOST_PORT_CONTROL, 8'hFF);
    rdc(HP_ADDR_SYSTEM_CONTROL);
    rdc(HP_ADDR_HOST_PORT_CONTROL);
    for (int ch = 1; ch <= 2; ch++) begin
      for (int s = 0; s <= 1; s++) begin
        host(1'b1, ch, s[0], 1'b0);
        chk({6'h00, cirq}, 8'(1 << (ch - 1)));
        rdc(ch == 1 ? HP_ADDR_ST1 : HP_ADDR_ST2);
        wr(ch == 1 ? HP_ADDR_IN1 : HP_ADDR_IN2, rnd());
        rdc(ch == 1 ? HP_ADDR_IN1 : HP_ADDR_IN2);
        rdc(ch == 1 ? HP_ADDR_ST1 : HP_ADDR_ST2);
      end
    end
    host(1'b1, 3, 1'b1, 1'b0);
    rdc(HP_ADDR_ST1);
    rdc(HP_ADDR_ST2);
    for (int ch = 1; ch <= 2; ch++) begin
      for (int m = 0; m <= 1; m++) begin
        expanded_mode = m[0];
        wr(ch == 1 ? HP_ADDR_OUT1 : HP_ADDR_OUT2, rnd());
        irqs();
        host(1'b0, ch, 1'b1, 1'b0);
        host(1'b0, ch, 1'b0, 1'b0);
        irqs();
        rdc(ch == 1 ? HP_ADDR_ST1 : HP_ADDR_ST2);
        rdc(ch == 1 ? HP_ADDR_OUT1 : HP_ADDR_OUT2);
      end
    end
    wr(HP_ADDR_SERIAL_TIMER_CONTROL, 8'h01);
    host(1'b1, 2, 1'b1, 1'b0);
    rdc(HP_ADDR_ST2);
    wr(HP_ADDR_HOST_PORT_CONTROL, 8'h02);
    host(1'b1, 2, 1'b1, 1'b1);
    chk({6'h00, cirq}, 8'h00);
    host(1'b0, 2, 1'b1, 1'b1);
    rdc(HP_ADDR_IN2);
    wr(HP_ADDR_SERIAL_TIMER_CONTROL, 8'h00);
    wr(HP_ADDR_ST1, 8'hFF);
    rdc(HP_ADDR_ST1);
    wr(HP_ADDR_OUT1, 8'h3C);
    wr(HP_ADDR_SYSTEM_CONTROL, 8'h00);
    host(1'b0, 1, 1'b0, 1'b0);
    rdc(HP_ADDR_ST1);
    end_sim();
  end
endmodule : dual_channel_host_port_decode_tb_top
`default_nettype wire
